// >>> hdl/sdp_packer.sv
// serial byte packer: delimiter, timeout and full-buffer framing, session control
`timescale 1ns/1ps
`include "sdp_params.svh"
// Function
// - with only delimiter one enabled, that byte alone packs and clears the buffer.
// - a full 1 KB buffer without delimiter is packed automatically.
// - delimiter detection works only while delimiter one is enabled.
// - with both enabled, only the two-byte sequence triggers the delimiter action.
// - pass-through mode sends the buffer, delimiter included, on the delimiter.
// - plus-one and plus-two modes wait one or two more bytes, then send all.
// - strip mode drops the delimiter bytes and sends the rest.
// - a force-transmit timeout of zero disables the inter-byte timeout.
// - 1 to 65535 ms without a new byte packs the whole buffer as one frame.
// - startup mode opens the session after reset and never closes it.
// - any-character modes open on first byte, optionally close on inactivity.
// - DSR modes open on DSR asserted, optionally close on DSR deasserted.
// - DCD modes open on DCD asserted, optionally close on DCD deasserted.
// - up to four destinations are connected and all receive each frame.
// - frames go to all open destinations in step; one slow one stalls all.
// - inactivity timeout closes an any-character/inactivity session after idle serial traffic; zero disables it.
module sdp_packer #(
    parameter int CYC_PER_MS = `SDP_MS_NS / `SDP_CLK_NS
) (
    // clock, enable and reset
    input wire logic clk_sys,
    input wire logic ce,
    input wire logic rstn,
    // register port
    input wire logic [`SDP_ADDR_W-1:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    // bytes from the serial receiver
    input wire logic rx_valid,
    input wire logic [7:0] rx_data,
    output logic rx_ready,
    // one pulse per byte sent out on the serial line
    input wire logic tx_activity,
    // modem status pins, asynchronous
    input wire logic dsr_pin,
    input wire logic dcd_pin,
    // frame stream towards the destinations
    output logic out_valid,
    output logic [7:0] out_data,
    output logic out_last,
    input wire logic [3:0] dest_ready,
    output logic [3:0] dest_connect,
    output logic session_open
);
    logic [31:0] ctrl;
    logic [`SDP_MS_W-1:0] ftx_ms, inact_ms, inact_limit;
    logic [7:0] delim1, delim2;
    logic en1, en2;
    sdp_pkg::sdp_proc_e proc;
    sdp_pkg::sdp_conn_e conn;
    logic [3:0] dest_en;
    sdp_pkg::sdp_state_e state, next_state;
    logic [1:0] left, next_left;
    logic [7:0] buf_mem [0:`SDP_BUF_BYTES-1];
    logic [`SDP_CNT_W-1:0] cnt, len, rd_idx, pack_len;
    logic rx_take, store, pack, complete;
    logic all_ready, load, drain_done, ftx_fire, inact_fire;
    logic [1:0] modem;
    logic dsr, dcd;

    assign delim1 = ctrl[`SDP_F_D1_LSB +: 8];
    assign delim2 = ctrl[`SDP_F_D2_LSB +: 8];
    assign en1 = ctrl[`SDP_F_EN1];
    assign en2 = ctrl[`SDP_F_EN2];
    assign proc = sdp_pkg::sdp_proc_e'(ctrl[`SDP_F_PROC_LSB +: 2]);
    assign conn = sdp_pkg::sdp_conn_e'(ctrl[`SDP_F_CONN_LSB +: 3]);
    assign dest_en = ctrl[`SDP_F_DEST_LSB +: 4];
    assign dsr = modem[0];
    assign dcd = modem[1];

    sdp_sync2 #(
        .WIDTH(2)
    ) u_sync (
        .clk_sys(clk_sys),
        .rstn(rstn),
        .ce(ce),
        .pin({dcd_pin, dsr_pin}),
        .level(modem)
    );

    // registers
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            ctrl <= `SDP_CTRL_RST;
            ftx_ms <= '0;
            inact_ms <= '0;
        end else if (ce && reg_wr) begin
            unique case (reg_addr)
                `SDP_REG_CTRL: ctrl <= reg_wdata;
                `SDP_REG_FTX: ftx_ms <= reg_wdata[`SDP_MS_W-1:0];
                `SDP_REG_INACT: inact_ms <= reg_wdata[`SDP_MS_W-1:0];
                default: ;
            endcase
        end
    end

    // unmapped addresses read as zero
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            reg_rdata <= '0;
        end else if (ce) begin
            reg_rdata <= '0;
            if (reg_rd) begin
                unique case (reg_addr)
                    `SDP_REG_CTRL: reg_rdata <= ctrl;
                    `SDP_REG_FTX: reg_rdata <= {16'h0000, ftx_ms};
                    `SDP_REG_INACT: reg_rdata <= {16'h0000, inact_ms};
                    `SDP_REG_STATUS: begin
                        reg_rdata[`SDP_ST_OPEN] <= session_open;
                        reg_rdata[`SDP_ST_DRAIN] <= (state == sdp_pkg::SDP_DRAIN);
                        reg_rdata[`SDP_ST_DEST_LSB +: 4] <= dest_connect;
                        reg_rdata[`SDP_ST_CNT_LSB +: `SDP_CNT_W] <= cnt;
                    end
                    default: ;
                endcase
            end
        end
    end

    assign rx_take = rx_valid && rx_ready;

    // framing decision for the byte taken this cycle
    always_comb begin
        next_state = state;
        next_left = left;
        store = 1'b0;
        pack = 1'b0;
        complete = 1'b0;
        pack_len = cnt;
        if (state == sdp_pkg::SDP_DRAIN) begin
            if (drain_done) begin
                next_state = sdp_pkg::SDP_HUNT;
                next_left = '0;
            end
        end else if (rx_take) begin
            store = 1'b1;
            pack_len = cnt + 1'b1;
            unique case (state)
                sdp_pkg::SDP_HUNT: begin
                    if (en1 && rx_data == delim1) begin
                        if (en2) begin
                            next_state = sdp_pkg::SDP_GOT1;
                        end else begin
                            complete = 1'b1;
                        end
                    end
                end
                sdp_pkg::SDP_GOT1: begin
                    if (rx_data == delim2) begin
                        complete = 1'b1;
                    end else if (rx_data != delim1) begin
                        next_state = sdp_pkg::SDP_HUNT;
                    end
                end
                sdp_pkg::SDP_EXTRA: begin
                    if (left == 2'h1) begin
                        pack = 1'b1;
                    end else begin
                        next_left = left - 1'b1;
                    end
                end
                default: ;
            endcase
            if (complete) begin
                unique case (proc)
                    sdp_pkg::SDP_PROC_NONE: pack = 1'b1;
                    sdp_pkg::SDP_PROC_PLUS1: begin
                        next_state = sdp_pkg::SDP_EXTRA;
                        next_left = 2'h1;
                    end
                    sdp_pkg::SDP_PROC_PLUS2: begin
                        next_state = sdp_pkg::SDP_EXTRA;
                        next_left = 2'h2;
                    end
                    sdp_pkg::SDP_PROC_STRIP: begin
                        store = 1'b0;
                        pack = 1'b1;
                        pack_len = en2 ? cnt - 1'b1 : cnt;
                    end
                endcase
            end
            // no delimiter and no timeout: every byte leaves at once
            if (!en1 && ftx_ms == '0) begin
                pack = 1'b1;
            end
            if (store && cnt + 1'b1 == `SDP_BUF_BYTES) begin
                pack = 1'b1;
            end
        end else if (ftx_fire && cnt != '0) begin
            pack = 1'b1;
        end
        if (pack) begin
            next_state = sdp_pkg::SDP_DRAIN;
            next_left = '0;
        end
    end

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            state <= sdp_pkg::SDP_HUNT;
            left <= '0;
            rx_ready <= 1'b1;
        end else if (ce) begin
            state <= next_state;
            left <= next_left;
            // the receiver is held off while a frame drains
            rx_ready <= (next_state != sdp_pkg::SDP_DRAIN);
        end
    end

    always_ff @(posedge clk_sys) begin
        if (ce && store) begin
            buf_mem[cnt[`SDP_IDX_W-1:0]] <= rx_data;
        end
    end

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            cnt <= '0;
            len <= '0;
        end else if (ce) begin
            if (drain_done) begin
                cnt <= '0;
            end else if (store) begin
                cnt <= cnt + 1'b1;
            end
            if (pack) begin
                len <= pack_len;
            end
        end
    end

    sdp_ms_timer #(
        .CYC_PER_MS(CYC_PER_MS)
    ) u_ftx (
        .clk_sys(clk_sys),
        .rstn(rstn),
        .ce(ce),
        .restart(rx_take && !pack),
        .clear(pack),
        .limit(ftx_ms),
        .fire(ftx_fire)
    );

    // only the any-character/inactivity mode arms the idle timer
    assign inact_limit = (conn == sdp_pkg::SDP_CONN_ANY_IDLE) ? inact_ms : '0;

    sdp_ms_timer #(
        .CYC_PER_MS(CYC_PER_MS)
    ) u_inact (
        .clk_sys(clk_sys),
        .rstn(rstn),
        .ce(ce),
        .restart(rx_take || tx_activity),
        .clear(!session_open),
        .limit(inact_limit),
        .fire(inact_fire)
    );

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            session_open <= 1'b0;
        end else if (ce) begin
            unique case (conn)
                sdp_pkg::SDP_CONN_STARTUP: session_open <= 1'b1;
                sdp_pkg::SDP_CONN_ANY: begin
                    if (rx_take) session_open <= 1'b1;
                end
                sdp_pkg::SDP_CONN_ANY_IDLE: begin
                    if (rx_take) begin
                        session_open <= 1'b1;
                    end else if (inact_fire) begin
                        session_open <= 1'b0;
                    end
                end
                sdp_pkg::SDP_CONN_DSR_OFF: session_open <= dsr;
                sdp_pkg::SDP_CONN_DSR: begin
                    if (dsr) session_open <= 1'b1;
                end
                sdp_pkg::SDP_CONN_DCD_OFF: session_open <= dcd;
                sdp_pkg::SDP_CONN_DCD: begin
                    if (dcd) session_open <= 1'b1;
                end
                default: session_open <= 1'b0;
            endcase
        end
    end

    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++) begin : g_dest
            always_ff @(posedge clk_sys or negedge rstn) begin
                if (!rstn) begin
                    dest_connect[gi] <= 1'b0;
                end else if (ce) begin
                    dest_connect[gi] <= session_open && dest_en[gi];
                end
            end
        end
    endgenerate

    // a frame with no open destination is dropped without stalling
    assign all_ready = &(dest_ready | ~dest_connect);
    assign load = (state == sdp_pkg::SDP_DRAIN) && (!out_valid || all_ready);
    assign drain_done = load && (rd_idx == len);

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            rd_idx <= '0;
            out_valid <= 1'b0;
            out_data <= '0;
            out_last <= 1'b0;
        end else if (ce) begin
            if (pack) begin
                rd_idx <= '0;
            end else if (load) begin
                if (rd_idx != len) begin
                    out_data <= buf_mem[rd_idx[`SDP_IDX_W-1:0]];
                    out_last <= (rd_idx + 1'b1 == len);
                    out_valid <= 1'b1;
                    rd_idx <= rd_idx + 1'b1;
                end else begin
                    out_valid <= 1'b0;
                    out_last <= 1'b0;
                end
            end
        end
    end
endmodule // sdp_packer

// >>> hdl/sdp_params.svh
// constants for the serial delimiter packer
`ifndef SDP_PARAMS_SVH
`define SDP_PARAMS_SVH

`define SDP_BUF_BYTES 11'h0400
`define SDP_CNT_W 11
`define SDP_IDX_W 10
`define SDP_MS_W 16
`define SDP_PRE_W 24
`define SDP_CLK_NS 100
`define SDP_MS_NS 1000000

`define SDP_ADDR_W 4
`define SDP_REG_CTRL 4'h0
`define SDP_REG_FTX 4'h4
`define SDP_REG_INACT 4'h8
`define SDP_REG_STATUS 4'hC

`define SDP_CTRL_RST 32'h0000_0000
`define SDP_F_D1_LSB 0
`define SDP_F_D2_LSB 8
`define SDP_F_EN1 16
`define SDP_F_EN2 17
`define SDP_F_PROC_LSB 18
`define SDP_F_CONN_LSB 20
`define SDP_F_DEST_LSB 24
`define SDP_ST_OPEN 0
`define SDP_ST_DRAIN 1
`define SDP_ST_DEST_LSB 4
`define SDP_ST_CNT_LSB 16

`endif

// >>> hdl/sdp_pkg.sv
// types shared by the serial delimiter packer
package sdp_pkg;

    typedef enum logic [3:0] {
        SDP_HUNT  = 4'b0001,
        SDP_GOT1  = 4'b0010,
        SDP_EXTRA = 4'b0100,
        SDP_DRAIN = 4'b1000
    } sdp_state_e;

    typedef enum logic [1:0] {
        SDP_PROC_NONE  = 2'h0,
        SDP_PROC_PLUS1 = 2'h1,
        SDP_PROC_PLUS2 = 2'h2,
        SDP_PROC_STRIP = 2'h3
    } sdp_proc_e;

    typedef enum logic [2:0] {
        SDP_CONN_STARTUP  = 3'h0,
        SDP_CONN_ANY      = 3'h1,
        SDP_CONN_ANY_IDLE = 3'h2,
        SDP_CONN_DSR_OFF  = 3'h3,
        SDP_CONN_DSR      = 3'h4,
        SDP_CONN_DCD_OFF  = 3'h5,
        SDP_CONN_DCD      = 3'h6,
        SDP_CONN_RSVD     = 3'h7
    } sdp_conn_e;

endpackage

// >>> hdl/sdp_sync2.sv
// two-flop synchroniser for the modem status pins
`timescale 1ns/1ps
`include "sdp_params.svh"
module sdp_sync2 #(
    parameter int WIDTH = 2
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rstn,
    input wire logic ce,
    // pins in, synchronised levels out
    input wire logic [WIDTH-1:0] pin,
    output logic [WIDTH-1:0] level
);
    logic [WIDTH-1:0] meta;

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            meta <= '0;
            level <= '0;
        end else if (ce) begin
            meta <= pin;
            level <= meta;
        end
    end
endmodule // sdp_sync2

// >>> hdl/sdp_ms_timer.sv
// millisecond timeout: restarts on demand, fires once when the limit passes
`timescale 1ns/1ps
`include "sdp_params.svh"
module sdp_ms_timer #(
    parameter int CYC_PER_MS = `SDP_MS_NS / `SDP_CLK_NS
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rstn,
    input wire logic ce,
    // control
    input wire logic restart,
    input wire logic clear,
    input wire logic [`SDP_MS_W-1:0] limit,
    // one-cycle pulse on expiry
    output logic fire
);
    localparam logic [`SDP_PRE_W-1:0] PRE_LAST = `SDP_PRE_W'(CYC_PER_MS - 1);
    logic [`SDP_PRE_W-1:0] pre;
    logic [`SDP_MS_W-1:0] ms;
    logic run;
    logic tick;

    assign tick = run && (pre == PRE_LAST);

    // a zero limit never arms, so the timeout stays off
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            pre <= '0;
            ms <= '0;
            run <= 1'b0;
            fire <= 1'b0;
        end else if (ce) begin
            fire <= 1'b0;
            if (restart) begin
                pre <= '0;
                ms <= '0;
                run <= (limit != '0);
            end else if (clear) begin
                run <= 1'b0;
            end else if (run) begin
                pre <= tick ? '0 : pre + 1'b1;
                if (tick) begin
                    ms <= ms + 1'b1;
                    if (ms + 1'b1 == limit) begin
                        fire <= 1'b1;
                        run <= 1'b0;
                    end
                end
            end
        end
    end
endmodule // sdp_ms_timer

// >>> verification/sdp_packer_properties.sv
// port checker for the serial delimiter packer
`timescale 1ns/1ps
`include "sdp_params.svh"
module sdp_packer_chk (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rstn,
    // register port
    input wire logic [`SDP_ADDR_W-1:0] reg_addr,
    input wire logic reg_rd,
    input wire logic [31:0] reg_rdata,
    // streams
    input wire logic rx_valid,
    input wire logic rx_ready,
    input wire logic out_valid,
    input wire logic [7:0] out_data,
    input wire logic out_last,
    input wire logic [3:0] dest_ready,
    input wire logic [3:0] dest_connect,
    input wire logic session_open
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rstn);

    sequence s_take;
        rx_valid && rx_ready;
    endsequence
    sequence s_stall;
        out_valid && (dest_connect & ~dest_ready) != 4'h0;
    endsequence
    sequence s_last;
        out_valid && out_last && (dest_ready & dest_connect) == dest_connect;
    endsequence

    chk_rdata_quiet:
    assert property (!reg_rd ##1 1'b1 |-> reg_rdata == 32'h0000_0000) else $error("rdata not zero");
    chk_status_open:
    assert property (reg_rd && reg_addr == `SDP_REG_STATUS |=> reg_rdata[0] == $past(session_open)
        && reg_rdata[7:4] == $past(dest_connect)) else $error("status mismatch");
    chk_connect_gate:
    assert property (!$past(session_open) |-> dest_connect == 4'h0) else $error("connect while shut");
    chk_drain_block:
    assert property (out_valid |-> !rx_ready) else $error("input open while draining");
    chk_stall_hold:
    assert property (s_stall |=> out_valid && $stable(out_data) && $stable(out_last))
        else $error("byte moved during stall");
    chk_frame_end:
    assert property (s_last |=> !out_valid && rx_ready) else $error("bad frame end");
    chk_frame_start:
    assert property ($rose(out_valid) |-> !rx_ready && !$past(rx_ready))
        else $error("frame started early");
    chk_last_valid:
    assert property (out_last |-> out_valid) else $error("last without valid");

    cover property (s_take ##1 !rx_ready);
    cover property (s_stall);
endmodule // sdp_packer_chk

bind sdp_packer sdp_packer_chk chk_u (.clk_sys(clk_sys), .rstn(rstn), .reg_addr(reg_addr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .rx_valid(rx_valid), .rx_ready(rx_ready),
    .out_valid(out_valid), .out_data(out_data), .out_last(out_last), .dest_ready(dest_ready),
    .dest_connect(dest_connect), .session_open(session_open));

// >>> verification/sdp_serial_dev.sv
// serial device model: offers queued bytes and drives the modem status lines
`timescale 1ns/1ps
module sdp_serial_dev (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rstn,
    // byte stream towards the packer
    input wire logic rx_ready,
    output logic rx_valid,
    output logic [7:0] rx_data,
    // modem status lines
    output logic dsr_pin,
    output logic dcd_pin
);
    logic [7:0] q[$];
    int gap = 0;
    int wait_cnt = 0;

    initial begin
        dsr_pin = 1'b0;
        dcd_pin = 1'b0;
    end

    task automatic send(input logic [7:0] b);
        q.push_back(b);
    endtask

    task automatic modem(input logic dsr, input logic dcd);
        @(posedge clk_sys);
        dsr_pin <= dsr;
        dcd_pin <= dcd;
    endtask

    // idle line shows a changing pattern so stale data can never look valid
    always @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            rx_valid <= 1'b0;
            rx_data <= 8'h00;
        end else if (!rx_valid || rx_ready) begin
            if (q.size() > 0 && wait_cnt == 0) begin
                rx_valid <= 1'b1;
                rx_data <= q.pop_front();
                wait_cnt <= gap;
            end else begin
                rx_valid <= 1'b0;
                rx_data <= ~rx_data;
                if (wait_cnt > 0) wait_cnt <= wait_cnt - 1;
            end
        end
    end
endmodule // sdp_serial_dev

// >>> verification/sdp_packer_tb.sv
// self-checking bench for the serial delimiter packer
`timescale 1ns/1ps
`include "sdp_params.svh"
module sdp_packer_tb;
    localparam int CPM = 8;
    logic clk_sys = 1'b0;
    logic rstn = 1'b0;
    logic [3:0] reg_addr = 4'h0;
    logic [31:0] reg_wdata = 32'h0000_0000;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic tx_activity = 1'b0;
    logic ce = 1'b1;
    logic [3:0] dest_ready = 4'hF;
    logic [31:0] reg_rdata;
    logic rx_valid, rx_ready, dsr_pin, dcd_pin, out_valid, out_last, session_open;
    logic [7:0] rx_data, out_data;
    logic [3:0] dest_connect;
    logic [1:0] ph = 2'h0;
    logic slow = 1'b0;
    logic [7:0] got[$];
    int frames = 0;
    int bad_count = 0;
    int tests_run = 0;

    always #50 clk_sys = ~clk_sys;

    sdp_packer #(.CYC_PER_MS(CPM)) dut_u (.clk_sys(clk_sys), .ce(ce), .rstn(rstn),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .rx_valid(rx_valid), .rx_data(rx_data), .rx_ready(rx_ready),
        .tx_activity(tx_activity), .dsr_pin(dsr_pin), .dcd_pin(dcd_pin),
        .out_valid(out_valid), .out_data(out_data), .out_last(out_last),
        .dest_ready(dest_ready), .dest_connect(dest_connect), .session_open(session_open));

    sdp_serial_dev dev_u (.clk_sys(clk_sys), .rstn(rstn), .rx_ready(rx_ready),
        .rx_valid(rx_valid), .rx_data(rx_data), .dsr_pin(dsr_pin), .dcd_pin(dcd_pin));

    // destination 0 lags on alternate cycle pairs while slow is set
    always @(posedge clk_sys) begin
        ph <= ph + 2'h1;
        dest_ready <= slow ? {3'b111, ph[1]} : 4'hF;
        if (out_valid && dest_connect != 4'h0 && (dest_ready & dest_connect) == dest_connect) begin
            got.push_back(out_data);
            if (out_last) frames++;
        end
    end

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            bad_count++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic wrap_up();
        $display("checks %0d mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge clk_sys);
    endtask

    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
    endtask

    task automatic rd(input logic [3:0] a, output logic [31:0] d);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        #1 d = reg_rdata;
    endtask

    // control word with both low destinations enabled
    function automatic logic [31:0] ctrl(input logic [7:0] d1, input logic [7:0] d2,
        input logic [1:0] en, input logic [1:0] pr, input logic [2:0] cn);
        return {4'h0, 4'b0011, 1'b0, cn, pr, en, d2, d1};
    endfunction

    task automatic frame(input logic [7:0] s[$], input logic [7:0] e[$], input int nf);
        int n;
        foreach (s[i]) dev_u.send(s[i]);
        for (n = 0; n < 5000 && frames < nf; n++) @(posedge clk_sys);
        if (frames < nf) begin
            bad_count++;
            wrap_up();
        end
        check("frames", frames, nf);
        check("length", got.size(), e.size());
        if (got.size() == e.size()) foreach (e[i]) check("byte", got[i], e[i]);
        frames = 0;
        got.delete();
    endtask

    initial begin
        logic [31:0] v;
        logic [7:0] s[$];
        cyc(10);
        rstn <= 1'b1;
        cyc(2);
        check("startup open", session_open, 1);
        wr(`SDP_REG_CTRL, ctrl(8'h0D, 8'h00, 2'b01, 2'h0, 3'h0));
        cyc(2);
        check("connect", dest_connect, 4'b0011);
        rd(`SDP_REG_STATUS, v);
        check("status", v[7:0], 8'h31);
        rd(4'h2, v);
        check("unmapped", v, 0);
        ce <= 1'b0;
        wr(`SDP_REG_FTX, 32'h0000_0005);
        ce <= 1'b1;
        rd(`SDP_REG_FTX, v);
        check("frozen", v, 32'h0000_0000);
        slow <= 1'b1;
        frame('{8'h41, 8'h42, 8'h0D}, '{8'h41, 8'h42, 8'h0D}, 1);
        slow <= 1'b0;
        wr(`SDP_REG_CTRL, ctrl(8'h0D, 8'h0A, 2'b11, 2'h0, 3'h0));
        s = '{8'h58, 8'h0D, 8'h59, 8'h0D, 8'h0A};
        frame(s, s, 1);
        wr(`SDP_REG_CTRL, ctrl(8'h00, 8'h0D, 2'b10, 2'h0, 3'h0));
        frame('{8'h41, 8'h0D}, '{8'h41, 8'h0D}, 2);
        for (int p = 1; p < 3; p++) begin
            wr(`SDP_REG_CTRL, ctrl(8'h0D, 8'h00, 2'b01, p[1:0], 3'h0));
            s = '{8'h50, 8'h0D, 8'h51, 8'h52};
            if (p == 1) s.pop_back();
            frame(s, s, 1);
            s[0] = 8'h53;
            frame(s, s, 1);
        end
        wr(`SDP_REG_CTRL, ctrl(8'h0D, 8'h00, 2'b01, 2'h3, 3'h0));
        frame('{8'h53, 8'h0D}, '{8'h53}, 1);
        wr(`SDP_REG_CTRL, ctrl(8'h0D, 8'h00, 2'b01, 2'h0, 3'h0));
        dev_u.send(8'h56);
        cyc(100);
        check("held", frames, 0);
        rd(`SDP_REG_STATUS, v);
        check("count", v, 32'h0001_0031);
        frame('{8'h0D}, '{8'h56, 8'h0D}, 1);
        wr(`SDP_REG_FTX, 32'h0000_0002);
        rd(`SDP_REG_FTX, v);
        check("ftx", v, 32'h0000_0002);
        dev_u.gap = 10;
        frame('{8'h54, 8'h55, 8'h57}, '{8'h54, 8'h55, 8'h57}, 1);
        dev_u.gap = 0;
        wr(`SDP_REG_FTX, 32'h0000_0000);
        s.delete();
        for (int i = 0; i < 1024; i++) s.push_back(8'h11);
        frame(s, s, 1);
        for (int i = 0; i < 3; i++) begin
            wr(`SDP_REG_CTRL, ctrl(8'h00, 8'h00, 2'b00, 2'h0, 3'h7));
            wr(`SDP_REG_INACT, i == 1 ? 32'h0000_0000 : 32'h0000_0003);
            wr(`SDP_REG_CTRL, ctrl(8'h00, 8'h00, 2'b00, 2'h0, i == 0 ? 3'h1 : 3'h2));
            cyc(3);
            check("closed", session_open, 0);
            dev_u.send(8'h61);
            cyc(6);
            check("opened", session_open, 1);
            cyc(12);
            tx_activity <= 1'b1;
            cyc(1);
            tx_activity <= 1'b0;
            cyc(16);
            check("kept", session_open, 1);
            cyc(40);
            check("idle end", session_open, i == 2 ? 0 : 1);
            frames = 0;
            got.delete();
        end
        for (int m = 3; m < 7; m++) begin
            wr(`SDP_REG_CTRL, ctrl(8'h00, 8'h00, 2'b00, 2'h0, 3'h7));
            wr(`SDP_REG_CTRL, ctrl(8'h00, 8'h00, 2'b00, 2'h0, m[2:0]));
            cyc(4);
            check("pin low", session_open, 0);
            dev_u.modem(m < 5, m >= 5);
            cyc(6);
            check("pin on", session_open, 1);
            dev_u.modem(1'b0, 1'b0);
            cyc(6);
            check("pin off", session_open, m[0] ? 0 : 1);
        end
        wrap_up();
    end

    initial begin
        cyc(100000);
        bad_count++;
        wrap_up();
    end
endmodule // sdp_packer_tb
